// >>> hw/srpg_gen.sv
// Purpose: Pattern generator for the converter alignment pulse
// Assumes: Plain register port; osc_i and loop_i synchronous to clock_i
// Notes:   Output changes only one cycle after an aligned divider tick, or when the generator is disabled
// Notes on behaviour
// - Clock source: oscillator or loop feedback.
// - 16-bit K divide, no fixed halving.
// - K spans 0 to 65535, two registers.
// - Pulses only on the aligned divider tick.
// - One bit picks software or pin requests.
// - Software requests are level, trigger bit.
// - Software burst clears trigger bit when done.
// - Software train runs while trigger bit set.
// - Pin level burst starts on rising pin.
// - Pin level train runs while pin high.
// - Edge style; bit picks active pin edge.
// - Edge burst ignores pin until finished.
// - Edge train starts on edge, then runs until reconfigured.
// - Mode field: burst, train, unused, stop.
// - Count field maps to 1,2,4,6,8 pulses.
// - Burst gives exactly N pulses, then low.
// - Train toggles at input over K.
// - Drives output only in internal source mode.
`include "srpg_regs.svh"

module srpg_gen (
  input  wire logic                    clock_i,    // System clock, 50 MHz
  input  wire logic                    reset_n_i,  // Asynchronous reset, active low
  input  wire logic [`SRPG_ADDR_W-1:0] addr_i,     // Register address
  input  wire logic [`SRPG_DATA_W-1:0] wdata_i,    // Write data
  input  wire logic                    wr_i,       // Write strobe
  input  wire logic                    rd_i,       // Read strobe
  input  wire logic                    osc_i,      // Oscillator input level
  input  wire logic                    loop_i,     // Loop feedback level
  input  wire logic                    pattern_request_pin_i,  // Async request
  output logic      [`SRPG_DATA_W-1:0] rdata_o,    // Read data, cycle after rd_i
  output logic                         sysref_o    // Generated pattern
);

  // Register storage
  logic [7:0]               k_lo_reg;     // K low byte
  logic [7:0]               k_hi_reg;     // K high byte
  logic [7:0]               req_ctl_reg;  // Request control
  logic [7:0]               pat_ctl_reg;  // Pattern control
  logic                     trig_prev_reg;  // Trigger bit one cycle ago

  // Request pin synchroniser and edge history
  logic                     pin_s1_reg;   // First stage, read only by second
  logic                     pin_s2_reg;   // Second stage, safe level
  logic                     pin_s3_reg;   // History for edge detection

  // Sequencer
  srpg_pkg::srpg_state_t    state_reg;    // Generator state
  logic [4:0]               left_reg;     // Output toggles still to make
  logic                     sysref_reg;   // Output level

  // Decoded controls
  logic                     div_tick;     // Aligned tick from the divider
  logic [1:0]               pat_mode;     // Pattern mode field
  logic [3:0]               n_count;      // Pulses per burst
  logic                     gen_en;       // Generator allowed to run
  logic                     sw_mode;      // Software requests
  logic                     edge_mode;    // Pin edge style
  logic                     is_cont;      // Continuous pattern selected
  logic                     lvl_now;      // Request level now
  logic                     lvl_old;      // Request level one cycle ago
  logic                     act_edge;     // Active pin edge seen
  logic                     start_req;    // Request to begin
  logic                     stay;         // Train may continue
  logic                     shot_done;    // Last toggle of a burst
  logic                     wr_req_ctl;   // Write to request control now
  logic                     hw_clear;     // Hardware clears the trigger bit

  // Burst length decode from the count field
  function automatic logic [3:0] shot_pulses(input logic [2:0] code);
    case (code)
      3'h1:    shot_pulses = 4'h1;
      3'h2:    shot_pulses = 4'h2;
      3'h3:    shot_pulses = 4'h4;
      3'h4:    shot_pulses = 4'h6;
      3'h5:    shot_pulses = 4'h8;
      default: shot_pulses = 4'h1;  // Code zero and codes six up give one
    endcase
  endfunction

  // Divider shared with the alignment grid
  srpg_kdiv u_kdiv (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .osc_i     (osc_i),
    .loop_i    (loop_i),
    .src_sel_i (req_ctl_reg[`SRPG_REQ_SRC_BIT]),
    .k_i       ({k_hi_reg, k_lo_reg}),
    .tick_o    (div_tick)
  );

  // Field decode
  assign pat_mode  = pat_ctl_reg[`SRPG_PAT_MODE_HI:`SRPG_PAT_MODE_LO];
  assign n_count   = shot_pulses(pat_ctl_reg[`SRPG_PAT_CNT_HI:`SRPG_PAT_CNT_LO]);
  assign is_cont   = (pat_mode == `SRPG_MODE_CONT);
  // Only the internal source codes with a usable pattern may run
  assign gen_en    = pat_ctl_reg[`SRPG_PAT_INT_BIT]
                   && (pat_mode != `SRPG_MODE_STOP)
                   && (pat_mode != `SRPG_MODE_PRBS);
  assign sw_mode   = !req_ctl_reg[`SRPG_REQ_PIN_BIT];
  // Software control ignores the edge bit and stays level sensitive
  assign edge_mode = !sw_mode && req_ctl_reg[`SRPG_REQ_EDGE_BIT];

  // Request level source
  always_comb begin
    if (sw_mode) begin
      lvl_now = req_ctl_reg[`SRPG_REQ_TRIG_BIT];
      lvl_old = trig_prev_reg;
    end else begin
      lvl_now = pin_s2_reg;
      lvl_old = pin_s3_reg;
    end
  end

  // Bit 5 low picks rising, high picks falling
  assign act_edge = req_ctl_reg[`SRPG_REQ_TRIG_BIT] ? (pin_s3_reg & ~pin_s2_reg)
                                                    : (pin_s2_reg & ~pin_s3_reg);

  // Start and hold conditions for each request style
  always_comb begin
    if (edge_mode) begin
      start_req = act_edge;
      stay      = 1'b1;
    end else if (is_cont) begin
      start_req = lvl_now;
      stay      = lvl_now;
    end else begin
      start_req = lvl_now & ~lvl_old;
      stay      = 1'b1;
    end
  end

  assign shot_done  = (state_reg == srpg_pkg::S_SHOT) && div_tick && (left_reg == 5'h01);
  assign wr_req_ctl = wr_i && (addr_i == `SRPG_OFF_REQ_CTL);
  assign hw_clear   = shot_done && sw_mode && !is_cont;

  // Request pin synchroniser; the first flop feeds only the second
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pattern_request_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Register writes; a software write beats the hardware clear
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      k_lo_reg      <= `SRPG_RST_BYTE;
      k_hi_reg      <= `SRPG_RST_BYTE;
      req_ctl_reg   <= `SRPG_RST_BYTE;
      pat_ctl_reg   <= `SRPG_RST_BYTE;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_prev_reg <= req_ctl_reg[`SRPG_REQ_TRIG_BIT];
      if (wr_i && (addr_i == `SRPG_OFF_K_LO)) begin
        k_lo_reg <= wdata_i;
      end else if (wr_i && (addr_i == `SRPG_OFF_K_HI)) begin
        k_hi_reg <= wdata_i;
      end else if (wr_i && (addr_i == `SRPG_OFF_PAT_CTL)) begin
        pat_ctl_reg <= wdata_i;
      end
      if (wr_req_ctl) begin
        req_ctl_reg <= wdata_i;
      end else if (hw_clear) begin
        req_ctl_reg[`SRPG_REQ_TRIG_BIT] <= 1'b0;
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= `SRPG_RST_BYTE;
    end else if (!rd_i) begin
      rdata_o <= `SRPG_RST_BYTE;
    end else if (addr_i == `SRPG_OFF_K_LO) begin
      rdata_o <= k_lo_reg;
    end else if (addr_i == `SRPG_OFF_K_HI) begin
      rdata_o <= k_hi_reg;
    end else if (addr_i == `SRPG_OFF_REQ_CTL) begin
      rdata_o <= req_ctl_reg;  // Shows the self-cleared trigger bit
    end else if (addr_i == `SRPG_OFF_PAT_CTL) begin
      rdata_o <= pat_ctl_reg;
    end else if (addr_i == `SRPG_OFF_STATUS) begin
      // Busy, output level and synchronised pin
      rdata_o <= {5'h00, (state_reg != srpg_pkg::S_IDLE), sysref_reg, pin_s2_reg};
    end else begin
      rdata_o <= `SRPG_RST_BYTE;  // Unmapped reads return zero
    end
  end

  // Sequencer and output; every output change waits for a divider tick, except the forced low when gen_en is low
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg  <= srpg_pkg::S_IDLE;
      left_reg   <= 5'h00;
      sysref_reg <= 1'b0;
    end else if (!gen_en) begin
      // External source, stop or unused code: static low, requests dropped
      state_reg  <= srpg_pkg::S_IDLE;
      left_reg   <= 5'h00;
      sysref_reg <= 1'b0;
    end else begin
      case (state_reg)
        srpg_pkg::S_IDLE: begin
          if (start_req) begin
            state_reg <= srpg_pkg::S_WAIT;
          end
        end
        srpg_pkg::S_WAIT: begin
          if (is_cont && !stay) begin
            state_reg <= srpg_pkg::S_IDLE;
          end else if (div_tick) begin
            sysref_reg <= 1'b1;
            if (is_cont) begin
              state_reg <= srpg_pkg::S_CONT;
            end else begin
              state_reg <= srpg_pkg::S_SHOT;
              left_reg  <= {n_count, 1'b0} - 5'h01;
            end
          end
        end
        srpg_pkg::S_SHOT: begin
          // Pin edges are not looked at here, so early edges are lost
          if (div_tick) begin
            sysref_reg <= ~sysref_reg;
            left_reg   <= left_reg - 5'h01;
            if (left_reg == 5'h01) begin
              state_reg <= srpg_pkg::S_IDLE;
            end
          end
        end
        srpg_pkg::S_CONT: begin
          // Stop only at a tick so the last pulse keeps its width
          if (div_tick) begin
            if (!stay || !is_cont) begin
              sysref_reg <= 1'b0;
              state_reg  <= srpg_pkg::S_IDLE;
            end else begin
              sysref_reg <= ~sysref_reg;
            end
          end
        end
        default: begin
          state_reg <= srpg_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign sysref_o = sysref_reg;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // Burst start on an aligned tick
  sequence shot_begin_s;
    (state_reg == srpg_pkg::S_WAIT) && gen_en && div_tick && !is_cont && stay;
  endsequence

  // Last burst toggle under software control
  sequence sw_shot_end_s;
    hw_clear && gen_en && !wr_req_ctl;
  endsequence

  stop_low_a: assert property ((pat_mode == `SRPG_MODE_STOP) |=> !sysref_o)
    else $error("stop mode did not hold the output low");

  prbs_low_a: assert property ((pat_mode == `SRPG_MODE_PRBS) |=> !sysref_o)
    else $error("unused mode code did not hold the output low");

  ext_src_low_a: assert property (!pat_ctl_reg[`SRPG_PAT_INT_BIT] |=> !sysref_o)
    else $error("output driven while an external source is selected");

  tick_align_a: assert property ($changed(sysref_o) |-> $past(div_tick) || $past(!gen_en))
    else $error("output changed away from an aligned tick");

  shot_load_a: assert property (shot_begin_s |=> sysref_o
    && (left_reg == ({$past(n_count), 1'b0} - 5'h01)))
    else $error("burst did not start high with the full toggle count");

  trig_clear_a: assert property (sw_shot_end_s |=> !req_ctl_reg[`SRPG_REQ_TRIG_BIT]
    ##1 (state_reg == srpg_pkg::S_IDLE) || !gen_en || start_req)
    else $error("trigger bit not cleared after the burst");

  edge_ignore_a: assert property ((state_reg == srpg_pkg::S_SHOT) && gen_en
    && act_edge && !div_tick |=> (left_reg == $past(left_reg)))
    else $error("pin edge disturbed a running burst");

  cont_toggle_a: assert property ((state_reg == srpg_pkg::S_CONT) && gen_en
    && div_tick && stay && is_cont |=> (sysref_o != $past(sysref_o)))
    else $error("train failed to toggle on the aligned tick");

  shot_end_a: assert property (shot_done && gen_en |=> !sysref_o
    && (state_reg == srpg_pkg::S_IDLE))
    else $error("burst did not end low and idle");

  // Independent tally of output pulses, kept apart from the toggle count
  logic       sys_prev_reg;  // Output level one cycle ago
  logic [3:0] seen_reg;      // Rising output edges since the burst began
  logic [3:0] want_reg;      // Burst length held from the start tick

  // Cleared while waiting, so the tally restarts with every request
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sys_prev_reg <= 1'b0;
      seen_reg     <= 4'h0;
      want_reg     <= 4'h0;
    end else begin
      sys_prev_reg <= sysref_reg;
      if (state_reg == srpg_pkg::S_WAIT) begin
        seen_reg <= 4'h0;             // Fresh tally
        want_reg <= n_count;          // Length in force at the start tick
      end else if (sysref_reg && !sys_prev_reg && (seen_reg != 4'hf)) begin
        seen_reg <= seen_reg + 4'h1;  // Saturates in a long train
      end
    end
  end

  // The burst carries exactly the programmed number of pulses
  shot_count_a: assert property (shot_done && gen_en |=> (seen_reg == want_reg))
    else $error("burst pulse count differs from the count field");

  // A request is taken into the wait state on the next edge
  start_take_a: assert property ((state_reg == srpg_pkg::S_IDLE) && gen_en && start_req
    |=> (state_reg == srpg_pkg::S_WAIT) && !sysref_o)
    else $error("request not taken into the wait state");

  // A train stops low at the tick after its request goes away
  train_stop_a: assert property ((state_reg == srpg_pkg::S_CONT) && gen_en && div_tick
    && !stay |=> !sysref_o && (state_reg == srpg_pkg::S_IDLE))
    else $error("train did not stop low on the aligned tick");

endmodule // srpg_gen

// >>> hw/srpg_regs.svh
// Purpose: Offsets, field positions and reset values of the pattern generator
// Assumes: Byte-wide registers at their printed byte offsets
// Notes:   Definitions only
`ifndef SRPG_REGS_SVH
`define SRPG_REGS_SVH

// Register bus geometry
`define SRPG_ADDR_W        16
`define SRPG_DATA_W        8

// Register offsets
`define SRPG_OFF_K_LO      16'h0400
`define SRPG_OFF_K_HI      16'h0401
`define SRPG_OFF_REQ_CTL   16'h0402
`define SRPG_OFF_PAT_CTL   16'h0403
`define SRPG_OFF_STATUS    16'h0404

// Request control field positions
`define SRPG_REQ_PIN_BIT   7
`define SRPG_REQ_EDGE_BIT  6
`define SRPG_REQ_TRIG_BIT  5
`define SRPG_REQ_SRC_BIT   4

// Pattern control field positions
`define SRPG_PAT_INT_BIT   7
`define SRPG_PAT_MODE_HI   5
`define SRPG_PAT_MODE_LO   4
`define SRPG_PAT_CNT_HI    3
`define SRPG_PAT_CNT_LO    1

// Pattern mode codes
`define SRPG_MODE_SHOT     2'h0
`define SRPG_MODE_CONT     2'h1
`define SRPG_MODE_PRBS     2'h2
`define SRPG_MODE_STOP     2'h3

// Reset values
`define SRPG_RST_BYTE      8'h00
`define SRPG_RST_K         16'h0000

`endif

// >>> hw/srpg_pkg.sv
// Purpose: Types shared by the pattern generator files
// Assumes: Constants live in srpg_regs.svh
// Notes:   Nothing here is imported; users write srpg_pkg::name
package srpg_pkg;

  // Generator sequencing states
  typedef enum logic [1:0] {
    S_IDLE,  // Waiting for a request
    S_WAIT,  // Request taken, waiting for the next aligned tick
    S_SHOT,  // Emitting a counted burst
    S_CONT   // Emitting a free-running pulse train
  } srpg_state_t;

endpackage : srpg_pkg

// >>> hw/srpg_kdiv.sv
// Purpose: K divider producing the aligned tick of the pattern generator
// Assumes: Both candidate sources are synchronous to clock_i
// Notes:   One tick every K rising edges of the selected source; K of 0 acts as 1
`include "srpg_regs.svh"

module srpg_kdiv (
  input  wire logic        clock_i,    // System clock
  input  wire logic        reset_n_i,  // Asynchronous reset, active low
  input  wire logic        osc_i,      // Oscillator input level
  input  wire logic        loop_i,     // Second-stage loop feedback level
  input  wire logic        src_sel_i,  // High selects the loop feedback
  input  wire logic [15:0] k_i,        // Programmed K value
  output logic             tick_o      // One-cycle aligned tick
);

  logic        sel_in;    // Selected source level
  logic        prev_reg;  // Source level one cycle ago
  logic        src_edge;  // Rising edge of the selected source
  logic [15:0] k_eff;     // K with zero mapped to one
  logic [15:0] cnt_reg;   // Source edges since the last tick
  logic        wrap;      // Count reaches K on this edge

  // Source choice; a switch may cost one stray edge, tolerated
  assign sel_in   = src_sel_i ? loop_i : osc_i;
  assign src_edge = sel_in & ~prev_reg;
  assign k_eff    = (k_i == 16'h0000) ? 16'h0001 : k_i;
  assign wrap     = (cnt_reg >= (k_eff - 16'h0001));

  // Edge history of the selected source
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sel_in;
    end
  end

  // Edge counter; free running so all outputs share its phase
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= `SRPG_RST_K;
      tick_o  <= 1'b0;
    end else begin
      tick_o <= src_edge & wrap;
      if (src_edge) begin
        cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
      end
    end
  end

  // Ticks never come on consecutive cycles
  tick_gap_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    tick_o |=> !tick_o)
    else $error("divider tick repeated on consecutive cycles");

endmodule // srpg_kdiv

// >>> tb/srpg_far_model.sv
// Purpose: Far side of the generator: oscillator, loop feedback, request pin
// Assumes: Both sources are synchronous to clock_i, as the design expects
// Notes:   Sources run free; the pin follows a bench command at clock edges
module srpg_far_model (
  input  wire logic clock_i,    // System clock
  input  wire logic pin_cmd_i,  // Pin level asked for by the bench
  output logic      osc_o,      // Oscillator, rising every 2 cycles
  output logic      loop_o,     // Loop feedback, rising every 4 cycles
  output logic      pin_o       // Request pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_reg = 2'h0;  // Source divider

  // Free-running sources; a crystal never pauses
  always_ff @(posedge clock_i) begin
    div_reg <= div_reg + 2'h1;
  end
  assign osc_o  = div_reg[0];
  assign loop_o = div_reg[1];

  // Bench only raises the pin once setup is done and drops it before reuse
  always_ff @(posedge clock_i) begin
    pin_o <= pin_cmd_i;
  end
endmodule // srpg_far_model

// >>> tb/sysref_pattern_generator_test.sv
// Purpose: Self-checking bench for the pattern generator
// Assumes: K=2 unless set otherwise; oscillator rises every 2 cycles
// Notes:   Pulse counts and widths come from a clocked output monitor
`include "srpg_regs.svh"

module sysref_pattern_generator_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock_i = 1'b0;  // 50 MHz clock
  logic        reset_n_i;       // Reset, active low
  logic [15:0] addr_i;          // Register address
  logic [7:0]  wdata_i;         // Write data
  logic        wr_i;            // Write strobe
  logic        rd_i;            // Read strobe
  logic [7:0]  rdata_o;         // Read data
  logic        osc_i;           // Oscillator from model
  logic        loop_i;          // Loop feedback from model
  logic        pin_i;           // Request pin from model
  logic        pin_cmd;         // Pin level asked of the model
  logic        sysref_o;        // Generated pattern
  logic [7:0]  d;               // Scratch read value
  int          failures;        // Mismatch count
  int          comparisons;     // Compare count
  int          pulse_cnt = 0;   // Rising edges seen on the output
  int          hi_run = 0;      // Current high run length
  int          last_width = 0;  // Width of the last full pulse
  int          base;            // Pulse count snapshot

  always #10 clock_i = ~clock_i;

  srpg_gen dut_u (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .osc_i(osc_i), .loop_i(loop_i),
    .pattern_request_pin_i(pin_i), .rdata_o(rdata_o), .sysref_o(sysref_o)
  );

  srpg_far_model far_u (
    .clock_i(clock_i), .pin_cmd_i(pin_cmd), .osc_o(osc_i), .loop_o(loop_i), .pin_o(pin_i)
  );

  // Output monitor: counts pulses and measures high widths in cycles
  // Samples on the falling edge, where the output has settled, so a count
  // window of n rising edges always spans exactly n samples
  always @(negedge clock_i) begin
    if (sysref_o === 1'b1) begin
      hi_run <= hi_run + 1;
      if (hi_run == 0) pulse_cnt <= pulse_cnt + 1;
    end else begin
      if (hi_run != 0) last_width <= hi_run;
      hi_run <= 0;
    end
  end

  task automatic stop_test();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
  endtask

  task automatic setup(input logic [7:0] req, input logic [7:0] pat);
    wr(`SRPG_OFF_PAT_CTL, pat);
    wr(`SRPG_OFF_REQ_CTL, req);
  endtask

  // Back to idle; clearing pattern control forces the output low at once
  task automatic idle();
    setup(8'h00, 8'h00);
    cyc(40);
  endtask

  task automatic quiet_window();
    base = pulse_cnt;
    cyc(40);
    check(16'(pulse_cnt - base), 16'h0000);
    check({15'h0, sysref_o}, 16'h0000);
  endtask

  function automatic int nexp(input int code);
    case (code)
      1: return 1; 2: return 2; 3: return 4; 4: return 6; 5: return 8;
      default: return 1;
    endcase
  endfunction

  task automatic t_regs();
    for (int a = 0; a < 4; a++) begin
      rd(`SRPG_OFF_K_LO + 16'(a), d);
      check({8'h0, d}, 16'h0000);
    end
    wr(`SRPG_OFF_K_LO, 8'h34);
    wr(`SRPG_OFF_K_HI, 8'h12);
    wr(16'h0405, 8'h5a);
    rd(`SRPG_OFF_K_LO, d);
    check({8'h0, d}, 16'h0034);
    rd(`SRPG_OFF_K_HI, d);
    check({8'h0, d}, 16'h0012);
    rd(16'h0405, d);
    check({8'h0, d}, 16'h0000);
    wr(`SRPG_OFF_K_HI, 8'h00);
    wr(`SRPG_OFF_K_LO, 8'h02);
  endtask

  // Software bursts for every count code, waiting for the self-clear
  task automatic t_soft_burst();
    for (int c = 0; c < 8; c++) begin
      base = pulse_cnt;
      setup(8'h20, 8'h80 | 8'(c << 1));
      for (int i = 0; i < 60; i++) begin
        rd(`SRPG_OFF_REQ_CTL, d);
        if (d[5] === 1'b0) break;
      end
      check({15'h0, d[5]}, 16'h0000);
      cyc(20);
      check(16'(pulse_cnt - base), 16'(nexp(c)));
      check(16'(last_width), 16'h0004);
      check({15'h0, sysref_o}, 16'h0000);
    end
  endtask

  // Software train at K of 0 and 3, then stop by clearing the trigger
  task automatic t_soft_cont();
    int kk;
    for (int k = 0; k < 4; k += 3) begin
      kk = (k == 0) ? 1 : k;
      wr(`SRPG_OFF_K_LO, 8'(k));
      setup(8'h20, 8'h90);
      cyc(12 * kk + 40);
      check(16'(last_width), 16'(2 * kk));
      idle();
    end
    wr(`SRPG_OFF_K_LO, 8'h02);
    setup(8'h20, 8'h90);
    cyc(40);
    rd(`SRPG_OFF_STATUS, d);
    check({15'h0, d[2]}, 16'h0001);
    base = pulse_cnt;
    cyc(40);
    check(16'(pulse_cnt - base), 16'h0005);
    wr(`SRPG_OFF_REQ_CTL, 8'h00);
    cyc(20);
    quiet_window();
  endtask

  // Unused mode, stop mode and external source must keep the output low
  task automatic t_blocked();
    logic [7:0] pats [3] = '{8'ha0, 8'hb0, 8'h10};
    foreach (pats[i]) begin
      setup(8'h20, pats[i]);
      cyc(20);
      quiet_window();
      idle();
    end
  endtask

  task automatic t_pin_level();
    setup(8'h80, 8'h84);
    quiet_window();
    base = pulse_cnt;
    pin_cmd <= 1'b1;
    cyc(80);
    check(16'(pulse_cnt - base), 16'h0002);
    pin_cmd <= 1'b0;
    cyc(10);
    setup(8'h80, 8'h90);
    pin_cmd <= 1'b1;
    cyc(20);
    rd(`SRPG_OFF_STATUS, d);
    check({14'h0, d[2], d[0]}, 16'h0003);
    base = pulse_cnt;
    cyc(40);
    check(16'(pulse_cnt - base), 16'h0005);
    check(16'(last_width), 16'h0004);
    pin_cmd <= 1'b0;
    cyc(20);
    quiet_window();
    idle();
  endtask

  // Edge style: mid-burst edge ignored, falling polarity, edge-started train
  task automatic t_edge();
    setup(8'hc0, 8'h86);
    base = pulse_cnt;
    pin_cmd <= 1'b1;
    cyc(4);
    pin_cmd <= 1'b0;
    cyc(12);
    pin_cmd <= 1'b1;
    cyc(4);
    pin_cmd <= 1'b0;
    cyc(80);
    check(16'(pulse_cnt - base), 16'h0004);
    setup(8'he0, 8'h86);
    pin_cmd <= 1'b1;
    cyc(20);
    quiet_window();
    base = pulse_cnt;
    pin_cmd <= 1'b0;
    cyc(80);
    check(16'(pulse_cnt - base), 16'h0004);
    setup(8'hc0, 8'h90);
    pin_cmd <= 1'b1;
    cyc(4);
    pin_cmd <= 1'b0;
    cyc(40);
    base = pulse_cnt;
    cyc(40);
    check(16'(pulse_cnt - base), 16'h0005);
    idle();
  endtask

  // Loop feedback rises half as often, so pulses are twice as wide
  task automatic t_loop_src();
    setup(8'h30, 8'h90);
    cyc(100);
    check(16'(last_width), 16'h0008);
    idle();
  endtask

  // Watchdog; the full sequence needs a few thousand cycles
  initial begin
    cyc(30000);
    failures++;
    stop_test();
  end

  initial begin
    failures    = 0;
    comparisons = 0;
    reset_n_i   = 1'b0;
    addr_i      = 16'h0000;
    wdata_i     = 8'h00;
    wr_i        = 1'b0;
    rd_i        = 1'b0;
    pin_cmd     = 1'b0;
    cyc(6);
    reset_n_i <= 1'b1;
    t_regs();
    t_soft_burst();
    t_soft_cont();
    t_blocked();
    t_pin_level();
    t_edge();
    t_loop_src();
    stop_test();
  end
endmodule // sysref_pattern_generator_test
